/* File: pacp_cfg.svh */
// timing constants and counts for the parallel async configuration port
`ifndef PACP_CFG_SVH
`define PACP_CFG_SVH

`define PACP_CLK_PERIOD_NS 25
`define PACP_T_CF2ST0_NS 800
`define PACP_T_CF2CD_NS 800
`define PACP_T_CF2ST1_US 40
`define PACP_T_STATUS_MIN_US 10
`define PACP_T_STATUS_MAX_US 40
`define PACP_T_WS2B_NS 20
`define PACP_T_BUSY_MIN_NS 7
`define PACP_T_BUSY_MAX_NS 45
`define PACP_T_RSD7_NS 20
`define PACP_T_CD2UM_MIN_US 6
`define PACP_T_CD2UM_MAX_US 20
`define PACP_USER_CLK_PERIODS 136
`define PACP_POR_CYCLES 64

`define PACP_MIN_CYC(ns) ((((ns) + `PACP_CLK_PERIOD_NS - 1) / `PACP_CLK_PERIOD_NS) < 1 ? 1 : \
  (((ns) + `PACP_CLK_PERIOD_NS - 1) / `PACP_CLK_PERIOD_NS))
`define PACP_MAX_CYC(ns) (((ns) / `PACP_CLK_PERIOD_NS) < 1 ? 1 : ((ns) / `PACP_CLK_PERIOD_NS))

`define PACP_CF2ST0_CYC `PACP_MAX_CYC(`PACP_T_CF2ST0_NS)
`define PACP_CF2CD_CYC `PACP_MAX_CYC(`PACP_T_CF2CD_NS)
`define PACP_CF2ST1_CYC `PACP_MAX_CYC(`PACP_T_CF2ST1_US * 1000)
`define PACP_STATUS_MIN_CYC `PACP_MIN_CYC(`PACP_T_STATUS_MIN_US * 1000)
`define PACP_STATUS_MAX_CYC `PACP_MAX_CYC(`PACP_T_STATUS_MAX_US * 1000)
`define PACP_BUSY_MIN_CYC `PACP_MIN_CYC(`PACP_T_BUSY_MIN_NS)
`define PACP_BUSY_MAX_CYC `PACP_MAX_CYC(`PACP_T_BUSY_MAX_NS)
`define PACP_CD2UM_MIN_CYC `PACP_MIN_CYC(`PACP_T_CD2UM_MIN_US * 1000)
`define PACP_CD2UM_MAX_CYC `PACP_MAX_CYC(`PACP_T_CD2UM_MAX_US * 1000)

`endif

/* File: pacp_pkg.sv */
// types shared by the parallel async configuration port
package pacp_pkg;

  typedef enum logic [7:0] {
    PACP_POR   = 8'h01,
    PACP_RESET = 8'h02,
    PACP_STAT  = 8'h04,
    PACP_LOAD  = 8'h08,
    PACP_ERR   = 8'h10,
    PACP_DONE  = 8'h20,
    PACP_START = 8'h40,
    PACP_USER  = 8'h80
  } pacp_state_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } pacp_byte_t;

  typedef struct packed {
    logic restartN;
    logic statusIn;
    logic confDoneIn;
    logic selectLowActive;
    logic selectHigh;
    logic writeStrobeN;
    logic statusReadStrobeN;
    logic [7:0] data;
  } pacp_pins_t;

endpackage

/* File: pacp_delay.sv */
// down counter that times one interval, stepping on an enable
`timescale 1ns/1ps
`include "pacp_cfg.svh"
module pacp_delay
  import pacp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic start,
  input wire logic [11:0] load,
  input wire logic step,
  // status
  output logic running
);

  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic run_q;
  logic run_d;
  wire lastStep = run_q && step && (cnt_q == 12'h001);

  assign cnt_d = start ? load : ((run_q && step) ? cnt_q - 12'h001 : cnt_q);
  assign run_d = start ? 1'b1 : (lastStep ? 1'b0 : run_q);
  assign running = run_q;

  // runs from reset so the power-on delay needs no start pulse
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cnt_q <= 12'(`PACP_POR_CYCLES);
      run_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
    end
  end

endmodule

/* File: pacp_port.sv */
// device side of the parallel async configuration port: reset, handshake, byte capture, start-up
// Operation
// - error status line goes low within 800 ns of restart falling
// - complete line goes low within 800 ns of restart falling
// - error status released within 40 us of restart rising unless stretched
// - own error status low pulse lasts 10 to 40 us
// - ready/busy falls within 20 ns of each write strobe rising edge; the code drops it only for edges while selected in the load state
// - ready/busy stays low 7 to 45 ns per accepted byte
// - ready/busy valid on top data bit within 20 ns of read strobe falling
// - top data bit is input for bytes, device output for status reads
// - user mode 6 to 20 us after complete, or 136 user clocks
// - error status held low through the power-on delay
// - complete line low from power-up until configuration finishes
// - after configuration the port pins stop serving configuration
// - one byte captured per write strobe rising edge while selected
// - error shown by driving error status low; host then restarts
`timescale 1ns/1ps
`include "pacp_cfg.svh"
module pacp_port
  import pacp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // configuration pins, sampled on clk
  input wire pacp_pins_t pins,
  // open-drain error status line, drives low while enabled
  output logic statusOut,
  output logic statusOe,
  // open-drain complete line, drives low while enabled
  output logic configCompleteOut,
  output logic configCompleteOe,
  // ready/busy pin, low while busy
  output logic readyBusyN,
  output logic readyBusyOe,
  // top data bit when read back
  output logic topDataBitOut,
  output logic topDataBitOe,
  // configuration core side
  output pacp_byte_t cfgByte,
  input wire logic coreError,
  input wire logic coreLastByte,
  // start-up clocking
  input wire logic useUserClock,
  input wire logic userStartupClock,
  // mode
  output logic userMode
);

  localparam int STATUS_MIN_CYC = `PACP_STATUS_MIN_CYC;
  localparam int STATUS_MAX_CYC = `PACP_STATUS_MAX_CYC;
  localparam int CF2ST1_CYC = `PACP_CF2ST1_CYC;
  localparam int CF2ST0_CYC = `PACP_CF2ST0_CYC;
  localparam int CF2CD_CYC = `PACP_CF2CD_CYC;
  localparam int CD2UM_MIN_CYC = `PACP_CD2UM_MIN_CYC;
  localparam int CD2UM_MAX_CYC = `PACP_CD2UM_MAX_CYC;
  localparam int BUSY_MIN_CYC = `PACP_BUSY_MIN_CYC;
  localparam int BUSY_MAX_CYC = `PACP_BUSY_MAX_CYC;

  function automatic logic drivesStatus(input pacp_state_t s);
    drivesStatus = (s == PACP_POR) || (s == PACP_RESET) || (s == PACP_STAT) || (s == PACP_ERR);
  endfunction

  function automatic logic drivesComplete(input pacp_state_t s);
    drivesComplete = (s != PACP_DONE) && (s != PACP_START) && (s != PACP_USER);
  endfunction

  pacp_state_t state_q;
  pacp_state_t state_d;
  logic wsPrev_q;
  logic ucPrev_q;
  logic [7:0] dataPrev_q;
  logic statusOe_q;
  logic completeOe_q;
  pacp_byte_t cfgByte_q;
  pacp_byte_t cfgByte_d;
  logic timerStart;
  logic [11:0] timerLoad;
  logic timerStep;
  logic timerRunning;

  // decoding of the sampled pins
  wire selected = !pins.selectLowActive && pins.selectHigh;
  wire wsRise = pins.writeStrobeN && !wsPrev_q;
  wire ucRise = userStartupClock && !ucPrev_q;
  wire loading = (state_q == PACP_LOAD);
  wire byteTaken = loading && selected && wsRise;
  wire startupLoad = (state_q == PACP_DONE) && pins.confDoneIn;
  wire statLoad = (state_q == PACP_RESET) && pins.restartN;
  // own drive ends
  // drop the pull once the low time is over, else the wire can never be seen high and a stretch is unseen
  wire ownStatusOver = (state_d == PACP_STAT) && !timerRunning && !timerStart;

  // restart low pulls every state except power-on back to reset
  // restart forces reset
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PACP_POR:
        if (!timerRunning)
          state_d = PACP_RESET;
      PACP_RESET:
        if (pins.restartN)
          state_d = PACP_STAT;
      PACP_STAT:
        if (!timerRunning && pins.statusIn)
          state_d = PACP_LOAD;
      PACP_LOAD:
        if (coreError)
          state_d = PACP_ERR;
        else if (coreLastByte)
          state_d = PACP_DONE;
      PACP_ERR:
        state_d = PACP_ERR;
      PACP_DONE:
        if (pins.confDoneIn)
          state_d = PACP_START;
      PACP_START:
        if (!timerRunning)
          state_d = PACP_USER;
      PACP_USER:
        state_d = PACP_USER;
      default:
        state_d = PACP_RESET;
    endcase
    if (!pins.restartN && (state_q != PACP_POR))
      state_d = PACP_RESET;
  end

  // one timer serves power-on, error status low time and start-up delay
  // status low and start-up timing
  assign timerStart = statLoad || startupLoad;
  assign timerLoad = statLoad ? 12'(STATUS_MIN_CYC) :
    (useUserClock ? 12'(`PACP_USER_CLK_PERIODS) : 12'(CD2UM_MIN_CYC));
  assign timerStep = ((state_q == PACP_START) && useUserClock) ? ucRise : 1'b1;

  pacp_delay i_pacp_delay (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(timerStart),
    .load(timerLoad),
    .step(timerStep),
    .running(timerRunning)
  );

  // byte capture on write rise
  // data was sampled the cycle before the edge, since hold after it is zero
  assign cfgByte_d = '{valid: byteTaken, data: byteTaken ? dataPrev_q : cfgByte_q.data};

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= PACP_POR;
      wsPrev_q <= 1'b1;
      ucPrev_q <= 1'b0;
      dataPrev_q <= 8'h00;
      statusOe_q <= 1'b1;
      completeOe_q <= 1'b1;
      cfgByte_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      wsPrev_q <= pins.writeStrobeN;
      ucPrev_q <= userStartupClock;
      dataPrev_q <= pins.data;
      statusOe_q <= drivesStatus(state_d) && !ownStatusOver;
      completeOe_q <= drivesComplete(state_d);
      cfgByte_q <= cfgByte_d;
    end
  end

  assign statusOut = 1'b0;
  assign statusOe = statusOe_q;
  assign configCompleteOut = 1'b0;
  assign configCompleteOe = completeOe_q;

  // busy in the edge cycle
  // busy lasts exactly the detect cycle, one clock sits inside the allowed window
  assign readyBusyN = !byteTaken;
  assign readyBusyOe = loading;
  // top bit turns around on read
  assign topDataBitOe = loading && !pins.statusReadStrobeN;
  assign topDataBitOut = readyBusyN;
  assign cfgByte = cfgByte_q;
  assign userMode = (state_q == PACP_USER);

  // helper counters for the interval checks
  logic [11:0] lowCnt_q;
  logic [11:0] startCnt_q;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      lowCnt_q <= 12'h000;
    else if ((state_q == PACP_STAT) && (lowCnt_q != 12'hfff))
      lowCnt_q <= lowCnt_q + 12'h001;
    else if (state_q != PACP_STAT)
      lowCnt_q <= 12'h000;
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      startCnt_q <= 12'h000;
    else if ((state_q == PACP_START) && (startCnt_q != 12'hfff))
      startCnt_q <= startCnt_q + 12'h001;
    else if (state_q != PACP_START)
      startCnt_q <= 12'h000;
  end

  sequence restartSeen;
    !pins.restartN && (state_q != PACP_POR);
  endsequence

  sequence byteEdge;
    byteTaken;
  endsequence

  status_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
    restartSeen |-> ##[1:2] statusOe)
    else $error("status not low after restart fell");

  done_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
    restartSeen |-> ##[1:2] configCompleteOe)
    else $error("complete line not low after restart fell");

  status_width_a: assert property (@(posedge clk) disable iff (sys_rst)
    ((state_q == PACP_STAT) && $fell(statusOe)) |->
      (lowCnt_q >= 12'(STATUS_MIN_CYC - 1)) && (lowCnt_q <= 12'(STATUS_MAX_CYC)))
    else $error("status low pulse out of range");

  status_release_a: assert property (@(posedge clk) disable iff (sys_rst)
    ((state_q == PACP_STAT) && (lowCnt_q == 12'(CF2ST1_CYC))) |-> !statusOe)
    else $error("status not released in time");

  busy_fall_a: assert property (@(posedge clk) disable iff (sys_rst)
    byteEdge |-> !readyBusyN && readyBusyOe)
    else $error("ready/busy not low on write edge");

  busy_width_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(readyBusyN) |-> ##1 readyBusyN)
    else $error("ready/busy low pulse too long");

  byte_capture_a: assert property (@(posedge clk) disable iff (sys_rst)
    byteEdge |=> cfgByte.valid && (cfgByte.data == $past(pins.data, 2)))
    else $error("captured byte wrong or missing");

  read_status_a: assert property (@(posedge clk) disable iff (sys_rst)
    (loading && !pins.statusReadStrobeN) |-> topDataBitOe && (topDataBitOut == readyBusyN))
    else $error("status not on top data bit");

  bit_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
    pins.statusReadStrobeN |-> !topDataBitOe)
    else $error("top data bit driven outside a read");

  startup_delay_a: assert property (@(posedge clk) disable iff (sys_rst)
    ($rose(userMode) && !useUserClock) |->
      ($past(startCnt_q) >= 12'(CD2UM_MIN_CYC - 1)) && ($past(startCnt_q) <= 12'(CD2UM_MAX_CYC)))
    else $error("user mode entered outside start-up window");

  por_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == PACP_POR) |-> statusOe && configCompleteOe && !userMode)
    else $error("status released during power-on delay");

  done_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    (loading && !coreLastByte) |=> configCompleteOe || (state_q == PACP_RESET))
    else $error("complete line released early");

  user_release_a: assert property (@(posedge clk) disable iff (sys_rst)
    userMode |-> !readyBusyOe && !topDataBitOe && !cfgByte.valid && !configCompleteOe)
    else $error("port pin still active in user mode");

  error_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (loading && coreError && pins.restartN) |=> statusOe [*8])
    else $error("error not shown on status line");

endmodule

/* File: pacp_host.sv */
// host model that drives the configuration pins and resolves the shared wires
`timescale 1ns/1ps
module pacp_host
  import pacp_pkg::*;
(
  // clock
  input wire logic clk,
  // device pin drivers
  input wire logic statusOe,
  input wire logic configCompleteOe,
  input wire logic topDataBitOut,
  input wire logic topDataBitOe,
  // pins as the device sees them
  output pacp_pins_t pins,
  output logic topDataWire
);
  logic restartN = 1'b1;
  logic stretchN = 1'b1;
  logic selLow = 1'b0;
  logic selHigh = 1'b1;
  logic wsN = 1'b1;
  logic rsN = 1'b1;
  logic [7:0] hostData = 8'h00;
  wire logic statusWire;
  wire logic doneWire;
  wire logic [7:0] busData;
  assign statusWire = ~statusOe & stretchN;
  assign doneWire = ~configCompleteOe;
  // host drives inverted data on the bus while reading
  assign busData = rsN ? hostData : ~hostData;
  assign topDataWire = topDataBitOe ? topDataBitOut : busData[7];
  assign pins = {restartN, statusWire, doneWire, selLow, selHigh, wsN, rsN, topDataWire, busData[6:0]};

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // one write pulse
  // strobe low for a whole cycle; callers space pulses three cycles apart, far above the ready gap
  task automatic write_byte(input logic [7:0] d, input logic sel);
    selLow = ~sel;
    selHigh = sel;
    hostData = d;
    wsN = 1'b0;
    step(1);
    wsN = 1'b1;
  endtask

  task automatic set_restart(input logic v);
    restartN = v;
  endtask

  task automatic set_stretch(input logic v);
    stretchN = v;
  endtask

  task automatic set_read(input logic v);
    rsN = v;
  endtask

  task automatic set_select(input logic v);
    selHigh = v;
  endtask
endmodule

/* File: pacp_port_bench.sv */
// self-checking bench for the parallel async configuration port
`timescale 1ns/1ps
`define CHECK(what, exp, act) begin num_checks++; if ((act) !== (exp)) begin bad_count++; \
  $display("[ERR] %s expected %h seen %h", what, exp, act); end end
module pacp_port_bench
  import pacp_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic coreError = 1'b0;
  logic coreLastByte = 1'b0;
  logic useUserClock = 1'b0;
  logic userStartupClock = 1'b0;
  int bad_count = 0;
  int num_checks = 0;
  pacp_pins_t pins;
  pacp_byte_t cfgByte;
  logic statusOut, statusOe, configCompleteOut, configCompleteOe;
  logic readyBusyN, readyBusyOe, topDataBitOut, topDataBitOe, userMode, topDataWire;

  initial forever #12.5 clk = ~clk;

  pacp_port i_pacp_port (.clk(clk), .sys_rst(sys_rst), .pins(pins), .statusOut(statusOut), .statusOe(statusOe),
    .configCompleteOut(configCompleteOut), .configCompleteOe(configCompleteOe), .readyBusyN(readyBusyN),
    .readyBusyOe(readyBusyOe), .topDataBitOut(topDataBitOut), .topDataBitOe(topDataBitOe), .cfgByte(cfgByte),
    .coreError(coreError), .coreLastByte(coreLastByte), .useUserClock(useUserClock),
    .userStartupClock(userStartupClock), .userMode(userMode));
  pacp_host i_pacp_host (.clk(clk), .statusOe(statusOe), .configCompleteOe(configCompleteOe),
    .topDataBitOut(topDataBitOut), .topDataBitOe(topDataBitOe), .pins(pins), .topDataWire(topDataWire));

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one write, judged at the strobe rise and one edge later
  task automatic do_write(input logic [7:0] d, input logic sel);
    i_pacp_host.write_byte(d, sel);
    #1;
    `CHECK("busy", ~sel, readyBusyN)
    i_pacp_host.step(1);
    `CHECK("ready", 1'b1, readyBusyN)
    `CHECK("valid", sel, cfgByte.valid)
    if (sel)
      `CHECK("data", d, cfgByte.data)
    i_pacp_host.step(1);
  endtask

  task automatic t_power();
    `CHECK("status por", 1'b1, statusOe)
    `CHECK("done por", 1'b1, configCompleteOe)
    `CHECK("status level", 1'b0, statusOut)
    `CHECK("done level", 1'b0, configCompleteOut)
    i_pacp_host.step(40);
    `CHECK("status por late", 1'b1, statusOe)
    `CHECK("user por", 1'b0, userMode)
    i_pacp_host.step(30);
    $display("test power done");
  endtask

  task automatic t_restart(input int stretch);
    int n;
    n = 0;
    i_pacp_host.set_restart(1'b0);
    while (!(statusOe === 1'b1 && configCompleteOe === 1'b1) && n < 40)
    begin
      i_pacp_host.step(1);
      n++;
    end
    `CHECK("restart low lines", 1'b1, n <= 32)
    i_pacp_host.step(1600 - n);
    i_pacp_host.set_restart(1'b1);
    i_pacp_host.set_stretch(stretch == 0);
    n = 0;
    while (pins.statusIn !== 1'b1 && n < 4000)
    begin
      i_pacp_host.step(1);
      n++;
      if (n == stretch)
        i_pacp_host.set_stretch(1'b1);
    end
    if (stretch == 0)
      `CHECK("status pulse", 1'b1, n >= 400 && n <= 1600)
    else
      `CHECK("stretched pulse", 1'b1, n >= stretch && n <= stretch + 2)
    `CHECK("own status off", 1'b0, statusOe)
    i_pacp_host.step((n < 1600) ? 1600 - n : 2);
    $display("test restart done");
  endtask

  task automatic t_bytes();
    logic [7:0] tbl [4];
    tbl = '{8'ha5, 8'h5a, 8'h80, 8'h01};
    foreach (tbl[i])
    begin
      do_write(tbl[i], 1'b1);
      i_pacp_host.set_select(1'b0);
      i_pacp_host.step(1);
    end
    do_write(8'h3c, 1'b0);
    `CHECK("kept data", 8'h01, cfgByte.data)
    `CHECK("top idle", 1'b0, topDataBitOe)
    `CHECK("rdy oe load", 1'b1, readyBusyOe)
    i_pacp_host.set_read(1'b0);
    #1;
    `CHECK("read oe", 1'b1, topDataBitOe)
    `CHECK("read ready", 1'b1, topDataWire)
    i_pacp_host.step(1);
    i_pacp_host.set_read(1'b1);
    i_pacp_host.step(1);
    `CHECK("read off", 1'b0, topDataBitOe)
    $display("test bytes done");
  endtask

  task automatic t_error();
    coreError = 1'b1;
    i_pacp_host.step(1);
    coreError = 1'b0;
    `CHECK("error low", 1'b1, statusOe)
    i_pacp_host.step(100);
    `CHECK("error held", 1'b1, statusOe)
    do_write(8'h77, 1'b0);
    $display("test error done");
  endtask

  task automatic t_done(input logic userClk);
    int n;
    int edges;
    n = 0;
    edges = 0;
    useUserClock = userClk;
    coreLastByte = 1'b1;
    i_pacp_host.step(1);
    coreLastByte = 0;
    `CHECK("done released", 1'b0, configCompleteOe)
    while (userMode !== 1'b1 && n < 2000)
    begin
      if (userClk && n % 2 == 0)
      begin
        userStartupClock = ~userStartupClock;
        edges += userStartupClock;
      end
      i_pacp_host.step(1);
      n++;
    end
    if (userClk)
      `CHECK("user clock start", 1'b1, edges >= 136 && edges <= 138)
    else
      `CHECK("osc start", 1'b1, n >= 240 && n <= 800)
    `CHECK("rdy oe user", 1'b0, readyBusyOe)
    i_pacp_host.set_read(1'b0);
    #1;
    `CHECK("top oe user", 1'b0, topDataBitOe)
    i_pacp_host.step(1);
    i_pacp_host.set_read(1'b1);
    i_pacp_host.write_byte(8'h11, 1'b1);
    #1;
    `CHECK("user busy", 1'b1, readyBusyN)
    i_pacp_host.step(1);
    `CHECK("user valid", 1'b0, cfgByte.valid)
    i_pacp_host.step(1);
    $display("test done done");
  endtask

  initial
  begin
    i_pacp_host.step(5);
    sys_rst = 1'b0;
    t_power();
    t_restart(0);
    t_bytes();
    t_error();
    t_restart(2000);
    t_done(1'b0);
    t_restart(0);
    t_done(1'b1);
    final_report();
  end

  // watchdog well beyond the roughly 11000 cycles the tests need
  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    final_report();
  end
endmodule
